/* File: hw/port_power_pkg.sv */
// shared constants, register map and carrier types for port power control
package port_power_pkg;

    // port count and bus widths
    localparam int          NUM_PORTS       = 4;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;

    // clock rate and sampling of the shared pins
    localparam int          CLK_HZ          = 10_000_000;
    localparam int          SAMPLE_US       = 100;
    localparam int          SAMPLE_CYCLES   = (CLK_HZ / 1_000_000) * SAMPLE_US;

    // single low pulse assertion time, a least time: round up
    localparam int          OCS_SINGLE_MS   = 5;
    localparam int          SINGLE_SAMPLES  =
        (OCS_SINGLE_MS * 1000 + SAMPLE_US - 1) / SAMPLE_US;

    // double low pulse window, a longest time: round down
    localparam int          OCS_DOUBLE_MS   = 20;
    localparam int          DOUBLE_SAMPLES  =
        (OCS_DOUBLE_MS * 1000) / SAMPLE_US;

    // blanking after power on, hides the inrush dip
    localparam int          BLANK_US        = 1000;
    localparam int          BLANK_SAMPLES   =
        (BLANK_US + SAMPLE_US - 1) / SAMPLE_US;

    // counter widths
    localparam int          DIV_W           = 10;
    localparam int          RUN_W           = 8;
    localparam int          WIN_W           = 8;
    localparam int          BLANK_W         = 4;

    // register byte offsets
    localparam logic [7:0]  OFS_CTRL        = 8'h00;
    localparam logic [7:0]  OFS_POWER       = 8'h04;
    localparam logic [7:0]  OFS_BC_EN       = 8'h08;
    localparam logic [7:0]  OFS_CHG_SUPPLY  = 8'h0C;
    localparam logic [7:0]  OFS_STATUS      = 8'h10;
    localparam logic [7:0]  OFS_INT_STAT    = 8'h14;
    localparam logic [7:0]  OFS_INT_MASK    = 8'h18;
    localparam logic [7:0]  OFS_PGOOD       = 8'h1C;

    // control field positions
    localparam int          CTRL_GANGED_BIT = 0;
    localparam int          CTRL_PROC_BIT   = 1;
    localparam int          CTRL_POLY_BIT   = 2;

    // reset values
    localparam logic [2:0]  CTRL_RST        = 3'h0;
    localparam logic [3:0]  PORT_RST        = 4'h0;
    localparam logic [7:0]  PGOOD_RST       = 8'h32;
    localparam logic [31:0] RDATA_RST       = 32'h0000_0000;

    // control register fields
    typedef struct packed {
        logic poly_fuse;   // poly fuse in place of power switches
        logic proc_src;    // processor register owns port power
        logic ganged;      // one common pin for all ports
    } ctrl_t;

    // drive of one group of open-drain shared pins
    typedef struct packed {
        logic [NUM_PORTS-1:0] out;    // level driven while enabled
        logic [NUM_PORTS-1:0] oe;     // high while the pin is driven
        logic [NUM_PORTS-1:0] pu_en;  // internal pull-up enable
    } pin_drive_t;

    // drive of the single ganged pin
    typedef struct packed {
        logic out;
        logic oe;
        logic pu_en;
    } gang_drive_t;

endpackage : port_power_pkg

/* File: hw/hub_port_power.sv */
// downstream port power switching and over-current detection on shared pins
// Behaviour
// - battery charging can be enabled per port through a software mask
// - charging supply presence shown per port by releasing that port's pin
// - one open-drain pin per port carries power enable and fault sense
// - port power comes from hub logic or from the processor register
// - ganged or combined port control arrangement is selectable
// - ganged: one common pin switches and senses all ports together
// - combined: each port has its own independent pin
// - power off: pin driven low and internal pull-up switched off
// - power on: driver released, pull-up on, pin acts open drain
// - pin sampled continuously while the port is powered
// - consecutive low samples for the single pulse time mean over-current
// - two low groups within the double pulse window mean over-current
// - transient dips such as power-up inrush are filtered out
// - poly fuse uses same drive and sense; open fuse low is a fault
// - poly fuse mode reports zero power-on-to-power-good delay fields
module hub_port_power
    import port_power_pkg::*;
#(
    parameter int SAMPLE_DIV = SAMPLE_CYCLES  // cycles per pin sample
) (
    input  wire logic                  clk,              // 10 MHz core clock
    input  wire logic                  rst,              // sync reset, high
    input  wire logic [ADDR_W-1:0]     reg_addr,         // register byte addr
    input  wire logic [DATA_W-1:0]     reg_wdata,        // write data
    input  wire logic                  reg_wr,           // write strobe
    input  wire logic                  reg_rd,           // read strobe
    output logic      [DATA_W-1:0]     reg_rdata,        // read data, next cycle
    output logic                       irq,              // level interrupt
    input  wire logic [NUM_PORTS-1:0]  hub_power_req,    // hub logic requests
    input  wire logic [NUM_PORTS-1:0]  port_power_sense_pins_in, // pin levels
    output pin_drive_t                 port_power_sense_pins,    // pin drive
    input  wire logic                  ganged_power_sense_pin_in, // gang level
    output gang_drive_t                ganged_power_sense_pin,   // gang drive
    output logic [NUM_PORTS-1:0]       oc_change,        // fault pulses
    output logic [NUM_PORTS-1:0]       oc_active,        // latched faults
    output logic [7:0]                 power_good_delay_field_hs, // hs field
    output logic [7:0]                 power_good_delay_field_ss  // ss field
);

    // software registers
    ctrl_t                ctrl_ff;
    logic [NUM_PORTS-1:0] power_reg_ff;
    logic [NUM_PORTS-1:0] bc_en_ff;
    logic [NUM_PORTS-1:0] chg_supply_ff;
    logic [NUM_PORTS-1:0] int_stat_ff;
    logic [NUM_PORTS-1:0] int_mask_ff;
    logic [7:0]           pgood_hs_ff;
    logic [7:0]           pgood_ss_ff;
    logic [DATA_W-1:0]    rdata_ff;
    logic                 irq_ff;

    // power and fault state
    logic [NUM_PORTS-1:0] on_ff;
    logic                 gang_on_ff;
    logic [NUM_PORTS-1:0] oc_lat_ff;
    logic [NUM_PORTS-1:0] hit_ff;
    logic [NUM_PORTS-1:0] sense_ff;

    // sample divider
    logic [DIV_W-1:0]     div_ff;
    logic                 tick_ff;

    // combinational helpers
    logic [NUM_PORTS-1:0] req;
    logic                 gang_req;
    logic [NUM_PORTS-1:0] chg_on;
    logic [NUM_PORTS-1:0] nxt_on;
    logic                 nxt_gang_on;
    logic [NUM_PORTS-1:0] det_powered;
    logic [NUM_PORTS-1:0] det_low;
    logic                 wr_ctrl;
    logic                 rd_int;
    logic [DATA_W-1:0]    nxt_rdata;

    assign wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
    assign rd_int  = reg_rd && (reg_addr == OFS_INT_STAT);

    // register writes; processor power bits only steer when proc_src is set
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_ff       <= ctrl_t'(CTRL_RST);
            power_reg_ff  <= PORT_RST;
            bc_en_ff      <= PORT_RST;
            chg_supply_ff <= PORT_RST;
            int_mask_ff   <= PORT_RST;
            pgood_hs_ff   <= PGOOD_RST;
            pgood_ss_ff   <= PGOOD_RST;
        end else if (reg_wr) begin
            unique case (reg_addr)
                OFS_CTRL:       ctrl_ff       <= ctrl_t'(reg_wdata[2:0]);
                OFS_POWER:      power_reg_ff  <= reg_wdata[3:0];
                OFS_BC_EN:      bc_en_ff      <= reg_wdata[3:0];
                OFS_CHG_SUPPLY: chg_supply_ff <= reg_wdata[3:0];
                OFS_INT_MASK:   int_mask_ff   <= reg_wdata[3:0];
                OFS_PGOOD: begin
                    pgood_hs_ff <= reg_wdata[7:0];
                    pgood_ss_ff <= reg_wdata[15:8];
                end
                default: ;
            endcase
        end
    end

    // read mux; unmapped offsets read as zero
    always_comb begin
        nxt_rdata = '0;
        unique case (reg_addr)
            OFS_CTRL:       nxt_rdata[2:0]  = ctrl_ff;
            OFS_POWER:      nxt_rdata[3:0]  = power_reg_ff;
            OFS_BC_EN:      nxt_rdata[3:0]  = bc_en_ff;
            OFS_CHG_SUPPLY: nxt_rdata[3:0]  = chg_supply_ff;
            OFS_STATUS: begin
                nxt_rdata[3:0]   = on_ff;
                nxt_rdata[7:4]   = oc_lat_ff;
                nxt_rdata[11:8]  = port_power_sense_pins_in;
                nxt_rdata[12]    = gang_on_ff;
                nxt_rdata[13]    = ganged_power_sense_pin_in;
            end
            OFS_INT_STAT:   nxt_rdata[3:0]  = int_stat_ff;
            OFS_INT_MASK:   nxt_rdata[3:0]  = int_mask_ff;
            OFS_PGOOD: begin
                nxt_rdata[7:0]  = pgood_hs_ff;
                nxt_rdata[15:8] = pgood_ss_ff;
            end
            default:        nxt_rdata       = '0;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_ff <= RDATA_RST;
        end else if (reg_rd) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= RDATA_RST;
        end
    end

    // sticky fault status, cleared by reading it; a new fault beats the clear
    always_ff @(posedge clk) begin
        if (rst) begin
            int_stat_ff <= PORT_RST;
        end else begin
            int_stat_ff <= (rd_int ? PORT_RST : int_stat_ff) | hit_ff;
        end
    end

    // interrupt level, one cycle behind the status bits
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(int_stat_ff & int_mask_ff);
        end
    end

    // power source selection and charging release
    always_comb begin
        req         = ctrl_ff.proc_src ? power_reg_ff : hub_power_req;
        gang_req    = |req;
        chg_on      = bc_en_ff & chg_supply_ff;
        nxt_gang_on = ctrl_ff.ganged && gang_req && !oc_lat_ff[0];
        if (ctrl_ff.ganged) begin
            nxt_on = chg_on;
        end else begin
            nxt_on = (req & ~oc_lat_ff) | chg_on;
        end
    end

    // pin state registers: driver and pull-up follow these
    always_ff @(posedge clk) begin
        if (rst) begin
            on_ff      <= PORT_RST;
            gang_on_ff <= 1'b0;
        end else begin
            on_ff      <= nxt_on;
            gang_on_ff <= nxt_gang_on;
        end
    end

    // open-drain drive: low with pull-up off when off, released when on
    always_comb begin
        port_power_sense_pins.out   = '0;
        port_power_sense_pins.oe    = ~on_ff;
        port_power_sense_pins.pu_en = on_ff;
        ganged_power_sense_pin.out   = 1'b0;
        ganged_power_sense_pin.oe    = !gang_on_ff;
        ganged_power_sense_pin.pu_en = gang_on_ff;
    end

    // sample rate divider; one pulse every SAMPLE_DIV cycles
    always_ff @(posedge clk) begin
        if (rst) begin
            div_ff  <= '0;
            tick_ff <= 1'b0;
        end else if (div_ff == DIV_W'(SAMPLE_DIV - 1)) begin
            div_ff  <= '0;
            tick_ff <= 1'b1;
        end else begin
            div_ff  <= div_ff + DIV_W'(1);
            tick_ff <= 1'b0;
        end
    end

    // pins are captured on each sample pulse; in ganged mode port 0 senses the gang pin
    always_ff @(posedge clk) begin
        if (rst) begin
            sense_ff <= {NUM_PORTS{1'b1}};
        end else if (tick_ff) begin
            sense_ff    <= port_power_sense_pins_in;
            if (ctrl_ff.ganged) begin
                sense_ff[0] <= ganged_power_sense_pin_in;
            end
        end
    end

    // detector inputs; poly fuse uses the same path, an open fuse reads low
    always_comb begin
        det_low     = ~sense_ff;
        det_powered = ctrl_ff.ganged ? {{(NUM_PORTS-1){1'b0}}, gang_on_ff}
                                     : on_ff;
    end

    // one over-current detector per port
    for (genvar i = 0; i < NUM_PORTS; i++) begin : g_det
        logic [RUN_W-1:0]   run_ff;
        logic [WIN_W-1:0]   win_ff;
        logic               win_act_ff;
        logic               prev_low_ff;
        logic [BLANK_W-1:0] blank_ff;
        logic               hit_one_ff;
        logic               armed;
        logic               start;

        // each port keeps its own pulse flop so one process drives each bit
        assign hit_ff[i] = hit_one_ff;
        assign armed = (blank_ff == BLANK_W'(BLANK_SAMPLES));
        assign start = det_low[i] && !prev_low_ff;

        // blanking after power on keeps inrush dips from faulting
        always_ff @(posedge clk) begin
            if (rst || !det_powered[i]) begin
                blank_ff <= '0;
            end else if (tick_ff && !armed) begin
                blank_ff <= blank_ff + BLANK_W'(1);
            end
        end

        // low run length and rolling double pulse window
        always_ff @(posedge clk) begin
            if (rst || !det_powered[i] || !armed) begin
                run_ff      <= '0;
                win_ff      <= '0;
                win_act_ff  <= 1'b0;
                prev_low_ff <= 1'b0;
                hit_one_ff  <= 1'b0;
            end else if (tick_ff) begin
                prev_low_ff <= det_low[i];
                hit_one_ff  <= 1'b0;
                if (det_low[i]) begin
                    if (run_ff != RUN_W'(SINGLE_SAMPLES)) begin
                        run_ff <= run_ff + RUN_W'(1);
                    end
                    if (run_ff == RUN_W'(SINGLE_SAMPLES - 1)) begin
                        hit_one_ff <= 1'b1;
                    end
                end else begin
                    run_ff <= '0;
                end
                if (start && win_act_ff) begin
                    hit_one_ff <= 1'b1;
                    win_act_ff <= 1'b0;
                end else if (start) begin
                    win_act_ff <= 1'b1;
                    win_ff     <= '0;
                end else if (win_act_ff) begin
                    // window closes once its span has passed
                    if (win_ff == WIN_W'(DOUBLE_SAMPLES - 2)) begin
                        win_act_ff <= 1'b0;
                    end
                    win_ff <= win_ff + WIN_W'(1);
                end
            end else begin
                hit_one_ff <= 1'b0;
            end
        end
    end

    // latched fault: power stays off until the request is withdrawn, except on a port whose charging is released
    always_ff @(posedge clk) begin
        if (rst) begin
            oc_lat_ff <= PORT_RST;
        end else begin
            // a fault in the same cycle as the withdrawal still latches
            if (ctrl_ff.ganged) begin
                oc_lat_ff[0] <= (oc_lat_ff[0] & gang_req) | hit_ff[0];
            end else begin
                oc_lat_ff <= (oc_lat_ff & req) | hit_ff;
            end
        end
    end

    // descriptor delay fields forced to zero for poly fuse boards
    always_comb begin
        power_good_delay_field_hs = ctrl_ff.poly_fuse ? 8'h00
                                                      : pgood_hs_ff;
        power_good_delay_field_ss = ctrl_ff.poly_fuse ? 8'h00
                                                      : pgood_ss_ff;
    end

    // outputs
    assign reg_rdata = rdata_ff;
    assign irq       = irq_ff;
    assign oc_change = hit_ff;
    assign oc_active = oc_lat_ff;

    // mode write strobe is left unused; mode changes reach the ports without a drop cycle
    logic unused_wr_ctrl;
    assign unused_wr_ctrl = wr_ctrl;

endmodule : hub_port_power

/* File: testbench/hub_port_power_props.sv */
// assertion checker for pin drive, fault flags and read data
module hub_port_power_props
    import port_power_pkg::*;
#(
    parameter int SAMPLE_DIV = SAMPLE_CYCLES  // cycles per pin sample
) (
    input wire logic                 clk,                    // core clock
    input wire logic                 rst,                    // sync reset
    input wire logic                 reg_rd,                 // read strobe
    input wire logic [DATA_W-1:0]    reg_rdata,              // read data
    input wire logic                 irq,                    // interrupt
    input wire pin_drive_t           port_power_sense_pins,  // pin drive
    input wire gang_drive_t          ganged_power_sense_pin, // gang drive
    input wire logic [NUM_PORTS-1:0] oc_change,              // fault pulses
    input wire logic [NUM_PORTS-1:0] oc_active,              // latched
    input wire logic [7:0]           power_good_delay_field_hs // hs field
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] oe;
    logic [3:0] pu;
    gang_drive_t g;

    // short aliases keep each property on few lines
    assign oe = port_power_sense_pins.oe;
    assign pu = port_power_sense_pins.pu_en;
    assign g  = ganged_power_sense_pin;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_OFF_LOW: assert property (
        port_power_sense_pins.out == '0 && (oe & pu) == '0)
        else $error("driven pin not low or pull-up left on");
    AST_ON_OPEN: assert property (pu == ~oe)
        else $error("pin neither driven nor released");
    AST_GANG_PIN: assert property (
        !g.out && (g.pu_en == !g.oe))
        else $error("gang pin drive inconsistent");
    AST_PULSE_ONE: assert property (
        |oc_change |=> (oc_change & $past(oc_change)) == '0)
        else $error("fault pulse longer than one cycle");
    AST_LATCH_SET: assert property (
        |oc_change |=> (oc_active & $past(oc_change)) == $past(oc_change))
        else $error("fault pulse not latched");
    AST_LATCH_CAUSE: assert property (
        (oc_active & ~$past(oc_active) & ~$past(oc_change)) == '0)
        else $error("fault latched without pulse");
    AST_RDATA_ONE: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data outside its cycle");
    AST_RESET_STATE: assert property ($fell(rst) |->
        oe == 4'hF && g.oe && !irq && oc_active == '0 &&
        power_good_delay_field_hs == 8'h32)
        else $error("state after reset wrong");

    // main scenarios
    COV_FAULT: cover property (|oc_change);
    COV_IRQ: cover property ($rose(irq));
    COV_GANG: cover property (g.pu_en);
endmodule : hub_port_power_props

bind hub_port_power hub_port_power_props #(.SAMPLE_DIV(SAMPLE_DIV)) u_props (
    .clk(clk), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .port_power_sense_pins(port_power_sense_pins),
    .ganged_power_sense_pin(ganged_power_sense_pin),
    .oc_change(oc_change), .oc_active(oc_active),
    .power_good_delay_field_hs(power_good_delay_field_hs));

/* File: testbench/power_switch_model.sv */
// external power switches with open-drain fault outputs on the shared pins
module power_switch_model
    import port_power_pkg::*;
(
    input  wire logic       clk,   // core clock, floats the idle pattern
    input  wire pin_drive_t drv,   // device drive of port pins
    input  wire gang_drive_t gdrv, // device drive of gang pin
    input  wire logic [3:0] fault, // switch fault per port
    input  wire logic       gfault, // fault on the gang switch
    output logic      [3:0] lvl,   // resolved port pin levels
    output logic            glvl   // resolved gang pin level
);
    timeunit 1ns;
    timeprecision 1ns;
    logic tog = 1'b0;

    // an undriven pin without pull-up floats: show a changing level
    always @(posedge clk) tog <= ~tog;

    // wired-and of device driver and switch fault output
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            lvl[i] = (drv.oe[i] | fault[i]) ? 1'b0 :
                     (drv.pu_en[i] ? 1'b1 : tog);
        end
        glvl = (gdrv.oe | gfault) ? 1'b0 : (gdrv.pu_en ? 1'b1 : tog);
    end
endmodule : power_switch_model

/* File: testbench/hub_port_power_tb.sv */
// self-checking bench for port power switching and fault detection
module hub_port_power_tb;
    import port_power_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DIV = 4;
    typedef struct packed {
        logic [2:0] ctrl;
        logic [3:0] pwr, bc, chg, req, eoe;
        logic       egoe;
    } row_t;
    row_t rows [6] = '{
        '{3'h0, 4'h0, 4'h0, 4'h0, 4'h5, 4'hA, 1'b1},
        '{3'h2, 4'h3, 4'h0, 4'h0, 4'hC, 4'hC, 1'b1},
        '{3'h0, 4'h0, 4'h6, 4'h2, 4'h0, 4'hD, 1'b1},
        '{3'h1, 4'h0, 4'h0, 4'h0, 4'h8, 4'hF, 1'b0},
        '{3'h1, 4'h0, 4'h0, 4'h0, 4'h0, 4'hF, 1'b1},
        '{3'h4, 4'h0, 4'h0, 4'h0, 4'hF, 4'h0, 1'b1}};
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, glvl, gfault = 1'b0;
    logic [7:0] addr = 8'h00, hs, ss;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] req = 4'h0, lvl, fault = 4'h0, occ, oca;
    logic irq;
    pin_drive_t pd;
    gang_drive_t gd;
    int err_count = 0, check_count = 0, cycles = 0, n;

    always #50 clk = ~clk;

    hub_port_power #(.SAMPLE_DIV(DIV)) dut (.clk(clk), .rst(rst),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
        .reg_rdata(rdata), .irq(irq), .hub_power_req(req),
        .port_power_sense_pins_in(lvl), .port_power_sense_pins(pd),
        .ganged_power_sense_pin_in(glvl), .ganged_power_sense_pin(gd),
        .oc_change(occ), .oc_active(oca),
        .power_good_delay_field_hs(hs), .power_good_delay_field_ss(ss));
    power_switch_model u_sw (.clk(clk), .drv(pd), .gdrv(gd),
        .fault(fault), .gfault(gfault), .lvl(lvl), .glvl(glvl));

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    // hang guard well above the expected run length
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            err_count++;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask : cyc

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_write

    // data is looked at mid-cycle, the only cycle it stands
    task automatic reg_read(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, e);
    endtask : reg_read

    // counts cycles until a fault pulse on port p, up to lim
    task automatic wait_oc(input int p, input int lim, output int k);
        for (k = 0; k < lim; k++) begin
            @(negedge clk);
            if (occ[p] === 1'b1) return;
        end
    endtask : wait_oc

    initial begin
        cyc(12);
        rst <= 1'b0;
        @(negedge clk);
        chk({pd.oe, pd.pu_en, gd.oe, irq}, {4'hF, 4'h0, 2'b10});
        reg_read(8'h1C, 32'h3232);
        reg_read(8'h20, 32'h0);
        $display("reset test done");
        // table of arrangements and power sources
        foreach (rows[i]) begin
            reg_write(8'h00, {29'h0, rows[i].ctrl});
            reg_write(8'h04, {28'h0, rows[i].pwr});
            reg_write(8'h08, {28'h0, rows[i].bc});
            reg_write(8'h0C, {28'h0, rows[i].chg});
            req <= rows[i].req;
            cyc(3);
            @(negedge clk);
            chk({pd.oe, gd.oe}, {rows[i].eoe, rows[i].egoe});
            chk(hs, rows[i].ctrl[2] ? 8'h00 : 8'h32);
            chk(ss, rows[i].ctrl[2] ? 8'h00 : 8'h32);
        end
        $display("arrangement table done");
        // single long low on port 2, with a dip during power up first
        reg_write(8'h00, 32'h0);
        reg_write(8'h18, 32'h4);
        @(posedge clk);
        req <= 4'h4;
        fault <= 4'h4;
        wait_oc(2, 24, n);
        chk(n, 24);
        @(posedge clk);
        fault <= 4'h0;
        wait_oc(2, 36, n);
        chk(n, 36);
        @(posedge clk);
        fault <= 4'h4;
        wait_oc(2, 230, n);
        chk(n >= 195 && n <= 215, 1);
        cyc(3);
        @(negedge clk);
        chk({oca[2], pd.oe[2], irq}, 3'b111);
        reg_read(8'h14, 32'h4);
        @(negedge clk);
        chk(irq, 1'b0);
        reg_read(8'h14, 32'h0);
        @(posedge clk);
        req <= 4'h0;
        fault <= 4'h0;
        cyc(3);
        @(negedge clk);
        chk(oca, 4'h0);
        $display("single pulse test done");
        // double low groups on port 1, masked from the interrupt
        @(posedge clk);
        req <= 4'h2;
        cyc(50);
        fault <= 4'h2;
        cyc(12);
        fault <= 4'h0;
        wait_oc(1, 860, n);
        chk(n, 860);
        @(posedge clk);
        fault <= 4'h2;
        cyc(12);
        fault <= 4'h0;
        cyc(80);
        fault <= 4'h2;
        wait_oc(1, 40, n);
        chk(n < 40, 1);
        cyc(3);
        @(negedge clk);
        chk({oca[1], irq}, 2'b10);
        reg_read(8'h14, 32'h2);
        $display("double pulse test done");
        close_out();
    end
endmodule : hub_port_power_tb
